//--- pkg/lsr_map.vh
// Register map, command fields, slave addresses and reset values
`ifndef LSR_MAP_VH
`define LSR_MAP_VH
// Command byte fields
`define LSR_CMD_BIT     7
`define LSR_CLR_BIT     6
`define LSR_WORD_BIT    5
`define LSR_BLOCK_BIT   4
`define LSR_PTR_MSB     3
// Register offsets
`define LSR_OFF_PWR     4'h0
`define LSR_OFF_TIM     4'h1
`define LSR_OFF_LL0     4'h2
`define LSR_OFF_LL1     4'h3
`define LSR_OFF_HL0     4'h4
`define LSR_OFF_HL1     4'h5
`define LSR_OFF_IRQ     4'h6
`define LSR_OFF_TEST    4'h8
`define LSR_OFF_ID      4'hA
`define LSR_OFF_BLK     4'hB
`define LSR_OFF_C0L     4'hC
`define LSR_OFF_C0H     4'hD
`define LSR_OFF_C1L     4'hE
`define LSR_OFF_C1H     4'hF
// Reset values
`define LSR_RST_PTR     4'h0
`define LSR_RST_PWR     8'h00
`define LSR_RST_TIM     8'h02
`define LSR_RST_LIM     8'h00
`define LSR_RST_IRQ     8'h00
// Slave addresses by select level
`define LSR_ADDR_GND    7'h29
`define LSR_ADDR_FLOAT  7'h39
`define LSR_ADDR_VDD    7'h49
`define LSR_SEL_GND     2'h0
`define LSR_SEL_FLOAT   2'h1
// Byte count inserted by the result block read
`define LSR_BLK_COUNT   8'h04
// Bits per byte on the link
`define LSR_BYTE_BITS   4'h8
`endif

//--- rtl/lsr_top.v
// Two-wire slave front end with the light sensor register space
//
// What this block does
// - A written byte with bit 7 set is a command, never register data.
// - Low four command bits become the stored register pointer.
// - Data bytes after a command go to the pointed register.
// - Receive byte returns the register the stored pointer selects.
// - Send, receive, write byte, word and block transfers all work.
// - Plain write and combined read with repeated start work.
// - Block byte-count byte is ignored; length is what actually moves.
// - Reads keep sending bytes until the master answers not-acknowledge.
// - Master may read right after the address; device turns transmitter.
// - Pointer holds zero after reset.
// - Command bit 6 pulses an interrupt clear and never stays set.
// - Command bit 5 marks a two-byte word transfer.
// - Command bit 4 marks a block transfer.
// - Sixteen locations; 7, 9, B reserved, 8 factory test.
// - Channel results as low byte then high byte at C..F.
// - Block read at pointer B inserts count 4 then four result bytes.
// - The only block read with a count is the 32-bit result block.
// - Slave address picked by the select pin: low, floating or high.
`timescale 1ns/1ps
`include "lsr_map.vh"

module lsr_top #(
    parameter [7:0] PART_ID = 8'h5A  // Arbitrary identity value
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Two-wire link
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    // Address select pin, 0 low, 1 floating, 2 high
    input  wire [1:0]  addr_sel,
    // Conversion results
    input  wire [15:0] ch0_result,
    input  wire [15:0] ch1_result,
    // Register contents towards the sensor core
    output reg  [7:0]  power_control,
    output reg  [7:0]  integration_setup,
    output reg  [7:0]  low_limit_byte0,
    output reg  [7:0]  low_limit_byte1,
    output reg  [7:0]  high_limit_byte0,
    output reg  [7:0]  high_limit_byte1,
    output reg  [7:0]  irq_config,
    output reg         irq_clear
);

////////////////////////////////////////////////////////////////////////
// States, one-hot
//   idle : bus free, or frame addressed to another slave
//   rx   : shifting in an address or a written byte
//   ack  : device pulls SDA low for the acknowledge bit
//   tx   : device shifts out a read byte, MSB first
//   rack : master answers the read byte with ACK or NACK
// One-hot costs five flops; the case decode still compares all five state bits.
localparam [4:0] ST_IDLE = 5'b00001;
localparam [4:0] ST_RX   = 5'b00010;
localparam [4:0] ST_ACK  = 5'b00100;
localparam [4:0] ST_TX   = 5'b01000;
localparam [4:0] ST_RACK = 5'b10000;

// Pin synchroniser stages and filtered levels
reg  [2:0]  scl_sh;
reg  [2:0]  sda_sh;
reg         scl_f;
reg         sda_f;
reg         scl_d;
reg         sda_d;

// Address select stages and accepted level
reg  [1:0]  asel1;
reg  [1:0]  asel2;
reg  [1:0]  asel3;
reg  [1:0]  asel;

// Frame sequencing
reg  [4:0]  state;
reg  [3:0]  bit_cnt;
reg  [7:0]  shreg;
reg         addr_phase;
reg         rd_mode;
reg         ack_ok;

// Pointer and transfer kind from the last command byte
reg  [3:0]  ptr;
reg         word_f;
reg         block_f;
reg         skip_cnt;
reg         ins_cnt;

// Result snapshot, address match and read byte
reg  [31:0] snap;
reg  [6:0]  my_addr;
reg  [7:0]  tx_byte;

// Edges, all taken from the filtered levels
wire scl_rise = scl_f & ~scl_d;
wire scl_fall = ~scl_f & scl_d;
// SDA moving while SCL stays high marks start or stop
wire start_c  = scl_f & scl_d & sda_d & ~sda_f;
wire stop_c   = scl_f & scl_d & ~sda_d & sda_f;
// Pointer auto-step applies to word and block transfers only
wire step_ptr = word_f | block_f;
// Fall of SCL after the eighth bit ends a byte
wire byte_end = scl_fall && (bit_cnt == `LSR_BYTE_BITS);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers; a level counts once stages two and three agree
// Filters start high so a reset release is not taken for a start.
// Latency is about four clocks, well inside the link's low phase.
// No clock stretching: every reply must fit inside that low phase.
always @(posedge clk_sys) begin
    if (rst) begin
        scl_sh <= 3'h7;
        sda_sh <= 3'h7;
        scl_f  <= 1'b1;
        sda_f  <= 1'b1;
        scl_d  <= 1'b1;
        sda_d  <= 1'b1;
        asel1  <= 2'h0;
        asel2  <= 2'h0;
        asel3  <= 2'h0;
        asel   <= 2'h0;
    end else begin
        scl_sh <= {scl_sh[1:0], scl_in};
        sda_sh <= {sda_sh[1:0], sda_in};
        asel1  <= addr_sel;
        asel2  <= asel1;
        asel3  <= asel2;
        if (scl_sh[1] == scl_sh[2]) begin
            scl_f <= scl_sh[2];
        end
        if (sda_sh[1] == sda_sh[2]) begin
            sda_f <= sda_sh[2];
        end
        if (asel2 == asel3) begin
            asel <= asel3;
        end
        scl_d <= scl_f;
        sda_d <= sda_f;
    end
end

////////////////////////////////////////////////////////////////////////
// Slave address from the select level
// Values two and three both mean the pin is tied high.
// The level is resynchronised so a moving pin cannot glitch the match.
always @* begin
    if (asel == `LSR_SEL_GND) begin
        my_addr = `LSR_ADDR_GND;
    end else if (asel == `LSR_SEL_FLOAT) begin
        my_addr = `LSR_ADDR_FLOAT;
    end else begin
        my_addr = `LSR_ADDR_VDD;
    end
end

////////////////////////////////////////////////////////////////////////
// Read data; results come from a snapshot so a block is coherent
// Snapshot is taken at each address match, so the two bytes of a
// channel never come from different conversions.
// Inserted count byte overrides the pointer for one byte only.
// Reserved and factory test locations read as zero.
always @* begin
    if (ins_cnt) begin
        tx_byte = `LSR_BLK_COUNT;
    end else if (ptr == `LSR_OFF_PWR) begin
        tx_byte = power_control;
    end else if (ptr == `LSR_OFF_TIM) begin
        tx_byte = integration_setup;
    end else if (ptr == `LSR_OFF_LL0) begin
        tx_byte = low_limit_byte0;
    end else if (ptr == `LSR_OFF_LL1) begin
        tx_byte = low_limit_byte1;
    end else if (ptr == `LSR_OFF_HL0) begin
        tx_byte = high_limit_byte0;
    end else if (ptr == `LSR_OFF_HL1) begin
        tx_byte = high_limit_byte1;
    end else if (ptr == `LSR_OFF_IRQ) begin
        tx_byte = irq_config;
    end else if (ptr == `LSR_OFF_ID) begin
        tx_byte = PART_ID;
    end else if (ptr == `LSR_OFF_C0L) begin
        tx_byte = snap[7:0];
    end else if (ptr == `LSR_OFF_C0H) begin
        tx_byte = snap[15:8];
    end else if (ptr == `LSR_OFF_C1L) begin
        tx_byte = snap[23:16];
    end else if (ptr == `LSR_OFF_C1H) begin
        tx_byte = snap[31:24];
    end else begin
        tx_byte = 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////
// Link state machine, register writes and pointer handling
// Start and stop win over any state: a frame cut short by either
// leaves the device released and ready for the next address.
// Register writes land at the fall after the eighth bit, together
// with the acknowledge, so an acknowledged byte is already stored.
// Block commands skip one count byte; word and block step the pointer.
always @(posedge clk_sys) begin
    if (rst) begin
        // Registers and pointer take their power-on values
        state             <= ST_IDLE;
        bit_cnt           <= 4'h0;
        shreg             <= 8'h00;
        addr_phase        <= 1'b0;
        rd_mode           <= 1'b0;
        ack_ok            <= 1'b0;
        ptr               <= `LSR_RST_PTR;
        word_f            <= 1'b0;
        block_f           <= 1'b0;
        skip_cnt          <= 1'b0;
        ins_cnt           <= 1'b0;
        snap              <= 32'h00000000;
        sda_out           <= 1'b0;
        sda_oe            <= 1'b0;
        power_control     <= `LSR_RST_PWR;
        integration_setup <= `LSR_RST_TIM;
        low_limit_byte0   <= `LSR_RST_LIM;
        low_limit_byte1   <= `LSR_RST_LIM;
        high_limit_byte0  <= `LSR_RST_LIM;
        high_limit_byte1  <= `LSR_RST_LIM;
        irq_config        <= `LSR_RST_IRQ;
        irq_clear         <= 1'b0;
    end else begin
        // Pulse output drops unless a command sets it below
        irq_clear <= 1'b0;
        if (start_c) begin
            // Start or repeated start always reopens the address phase
            state      <= ST_RX;
            bit_cnt    <= 4'h0;
            addr_phase <= 1'b1;
            sda_oe     <= 1'b0;
        end else if (stop_c) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    // Shift in one bit per filtered rise
                    if (scl_rise && bit_cnt != `LSR_BYTE_BITS) begin
                        shreg   <= {shreg[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (byte_end && addr_phase) begin
                        // Address byte: compare and latch direction
                        addr_phase <= 1'b0;
                        if (shreg[7:1] == my_addr) begin
                            state   <= ST_ACK;
                            sda_oe  <= 1'b1;
                            rd_mode <= shreg[0];
                            snap    <= {ch1_result, ch0_result};
                        end else begin
                            // Not this slave: ignore until the next start
                            state <= ST_IDLE;
                        end
                    end else if (byte_end) begin
                        state  <= ST_ACK;
                        sda_oe <= 1'b1;
                        // Command byte: pointer and transfer kind
                        if (shreg[`LSR_CMD_BIT]) begin
                            ptr      <= shreg[`LSR_PTR_MSB:0];
                            word_f   <= shreg[`LSR_WORD_BIT];
                            block_f  <= shreg[`LSR_BLOCK_BIT];
                            skip_cnt <= shreg[`LSR_BLOCK_BIT];
                            ins_cnt  <= shreg[`LSR_BLOCK_BIT] &&
                                        (shreg[`LSR_PTR_MSB:0] == `LSR_OFF_BLK);
                            irq_clear <= shreg[`LSR_CLR_BIT];
                        end else if (skip_cnt) begin
                            // Count byte of a block write is dropped
                            skip_cnt <= 1'b0;
                        end else begin
                            // Read-only and reserved locations drop writes
                            if (ptr == `LSR_OFF_PWR) begin
                                power_control <= shreg;
                            end else if (ptr == `LSR_OFF_TIM) begin
                                integration_setup <= shreg;
                            end else if (ptr == `LSR_OFF_LL0) begin
                                low_limit_byte0 <= shreg;
                            end else if (ptr == `LSR_OFF_LL1) begin
                                low_limit_byte1 <= shreg;
                            end else if (ptr == `LSR_OFF_HL0) begin
                                high_limit_byte0 <= shreg;
                            end else if (ptr == `LSR_OFF_HL1) begin
                                high_limit_byte1 <= shreg;
                            end else if (ptr == `LSR_OFF_IRQ) begin
                                irq_config <= shreg;
                            end
                            if (step_ptr) begin
                                ptr <= ptr + 4'h1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // End of acknowledge: load a read byte or keep receiving
                    if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (rd_mode) begin
                            state  <= ST_TX;
                            shreg  <= tx_byte;
                            sda_oe <= ~tx_byte[7];
                            if (ins_cnt) begin
                                ins_cnt <= 1'b0;
                                ptr     <= `LSR_OFF_C0L;
                            end else if (step_ptr) begin
                                ptr <= ptr + 4'h1;
                            end
                        end else begin
                            state  <= ST_RX;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    // Next bit goes out after each fall, MSB first
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            // Release SDA for the master's answer
                            state  <= ST_RACK;
                            sda_oe <= 1'b0;
                        end else begin
                            shreg   <= {shreg[6:0], 1'b0};
                            sda_oe  <= ~shreg[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    // Master's answer is sampled at the rise
                    if (scl_rise) begin
                        ack_ok <= ~sda_f;
                    end else if (scl_fall) begin
                        bit_cnt <= 4'h0;
                        if (ack_ok) begin
                            // Master acknowledged: next byte follows
                            state  <= ST_TX;
                            shreg  <= tx_byte;
                            sda_oe <= ~tx_byte[7];
                            if (ins_cnt) begin
                                ins_cnt <= 1'b0;
                                ptr     <= `LSR_OFF_C0L;
                            end else if (step_ptr) begin
                                ptr <= ptr + 4'h1;
                            end
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    // Any illegal code returns to idle
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

endmodule

//--- verification/lsr_master.sv
// Behavioural two-wire bus master that drives the link for the bench
`timescale 1ns/1ps
module lsr_master (
    // Clock and wire level
    input  wire clk_sys,
    input  wire sda_wire,
    // Link drive, SDA is open drain
    output reg  scl,
    output reg  sda_low
);
    // Bus idle, both lines released high
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Wait a number of system clocks
    task tk(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    // One bit; SCL low 7 clk so the slave lets go of SDA first
    task bt(input b, output s);
        begin
            tk(3);
            sda_low <= !b;
            tk(4);
            scl <= 1'b1;
            tk(2);
            s = sda_wire;
            tk(1);
            scl <= 1'b0;
        end
    endtask
    // Eight bits MSB first plus the acknowledge bit
    task xb(input [8:0] o, output [8:0] s);
        integer i;
        for (i = 8; i >= 0; i = i - 1) bt(o[i], s[i]);
    endtask
    // Start or repeated start: SDA falls while SCL high
    task st;
        begin
            tk(3);
            sda_low <= 1'b0;
            tk(4);
            scl <= 1'b1;
            tk(5);
            sda_low <= 1'b1;
            tk(5);
            scl <= 1'b0;
        end
    endtask
    // Stop: SDA rises while SCL high, then idle
    task sp;
        begin
            tk(3);
            sda_low <= 1'b1;
            tk(4);
            scl <= 1'b1;
            tk(5);
            sda_low <= 1'b0;
            tk(10);
        end
    endtask
endmodule

//--- verification/lsr_top_asserts.sv
// Concurrent checks on the ports of the two-wire register slave
`timescale 1ns/1ps
`include "lsr_map.vh"
module lsr_top_asserts (
    // Clock and reset
    input wire       clk_sys,
    input wire       rst,
    // Link
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    // Registers
    input wire [7:0] power_control,
    input wire [7:0] integration_setup,
    input wire [7:0] low_limit_byte0,
    input wire [7:0] low_limit_byte1,
    input wire [7:0] high_limit_byte0,
    input wire [7:0] high_limit_byte1,
    input wire [7:0] irq_config,
    input wire       irq_clear
);
    // All writable registers in one vector
    wire [55:0] regs = {power_control, integration_setup, low_limit_byte0, low_limit_byte1,
                        high_limit_byte0, high_limit_byte1, irq_config};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_sda_out_low: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    a_reset_state: assert property (disable iff (1'b0) rst |=> !sda_oe && !irq_clear &&
        integration_setup == `LSR_RST_TIM && power_control == `LSR_RST_PWR && irq_config == `LSR_RST_IRQ)
        else $error("bad reset state");
    a_irq_one_cycle: assert property (irq_clear |=> !irq_clear)
        else $error("irq_clear longer than one cycle");
    a_irq_with_ack: assert property (irq_clear |-> ##[0:8] sda_oe)
        else $error("irq_clear without byte acknowledge");
    a_cmd_not_data: assert property (irq_clear |-> $stable(regs))
        else $error("command byte stored as data");
    a_reg_on_ack: assert property (!$stable(regs) |-> ##[0:8] sda_oe)
        else $error("register changed without acknowledge");
    a_bit_hold: assert property ($rose(sda_oe) |=> sda_oe [*4])
        else $error("sda drive too short");
    a_oe_scl_low: assert property (!$stable(sda_oe) |-> !scl_in)
        else $error("sda drive changed while scl high");
    a_stop_release: assert property (scl_in && $rose(sda_in) |=> !sda_oe [*8])
        else $error("sda driven after stop");
endmodule
bind lsr_top lsr_top_asserts lsr_top_asserts_i (.*);

//--- verification/lsr_top_test.sv
// Self-checking bench for the two-wire register slave
`timescale 1ns/1ps
`include "lsr_map.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("[FAIL] %0t %h vs %h", $time, a, e); end end
module lsr_top_test;
    localparam [7:0] PID = 8'hC3; // Arbitrary identity value
    reg         clk_sys = 1'b0;
    reg         rst = 1'b1;
    reg  [1:0]  addr_sel = 2'h0;
    reg  [15:0] ch0 = 16'h2211;
    reg  [15:0] ch1 = 16'h4433;
    wire        scl;
    wire        sda_low;
    wire        sda_out;
    wire        sda_oe;
    wire [7:0]  pc, ts, l0, l1, h0, h1, ic;
    wire        irq_clear;
    // Pull-up wire: low when either party pulls
    wire        sda_w = !(sda_low | sda_oe);
    integer     mismatches = 0;
    integer     checked = 0;
    integer     irqs = 0;
    integer     s, k;
    reg  [6:0]  dev = `LSR_ADDR_GND;
    reg  [8:0]  r;
    reg  [39:0] q;
    always #4 clk_sys = !clk_sys;
    always @(posedge clk_sys) if (irq_clear) irqs <= irqs + 1;
    lsr_master lsr_master_i (.clk_sys(clk_sys), .sda_wire(sda_w), .scl(scl), .sda_low(sda_low));
    lsr_top #(.PART_ID(PID)) lsr_top_i (.clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .ch0_result(ch0), .ch1_result(ch1),
        .power_control(pc), .integration_setup(ts), .low_limit_byte0(l0), .low_limit_byte1(l1),
        .high_limit_byte0(h0), .high_limit_byte1(h1), .irq_config(ic), .irq_clear(irq_clear));
    ////////////////////////////////////////////////////////////////
    // Master writes a byte; slave must acknowledge
    task wb(input [7:0] d);
        begin
            lsr_master_i.xb({d, 1'b1}, r);
            `CHK(r[0], 1'b0)
        end
    endtask
    // Write frame: command then n data bytes, lowest byte first
    task wr(input [7:0] c, input integer n, input [31:0] d);
        integer i;
        begin
            lsr_master_i.st;
            wb({dev, 1'b0});
            wb(c);
            for (i = 0; i < n; i = i + 1) wb(d[8*i +: 8]);
            lsr_master_i.sp;
        end
    endtask
    // Read frame, optional command and repeated start; last byte NACKed
    task rd(input [7:0] c, input w, input integer n);
        integer i;
        begin
            if (w) begin
                lsr_master_i.st;
                wb({dev, 1'b0});
                wb(c);
            end
            lsr_master_i.st;
            wb({dev, 1'b1});
            for (i = 0; i < n; i = i + 1) begin
                lsr_master_i.xb({8'hFF, i == n - 1}, r);
                q[8*i +: 8] = r[8:1];
            end
            lsr_master_i.sp;
        end
    endtask
    // Counts and verdict
    task tally_and_finish;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        tally_and_finish;
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        `CHK(ts, `LSR_RST_TIM)
        rd(0, 0, 1);
        `CHK(q[7:0], `LSR_RST_PWR)
        wr(8'h80, 1, 32'h03);
        `CHK(pc, 8'h03)
        rd(0, 0, 1);
        `CHK(q[7:0], 8'h03)
        wr(8'h81, 0, 0);
        rd(0, 0, 1);
        `CHK(q[7:0], `LSR_RST_TIM)
        $display("byte transfers done");
        wr(8'hA2, 2, 32'h1234);
        `CHK({l1, l0}, 16'h1234)
        rd(8'hA2, 1, 2);
        `CHK(q[15:0], 16'h1234)
        wr(8'h94, 3, 32'h785602);
        `CHK({h1, h0}, 16'h7856)
        rd(8'h9B, 1, 5);
        `CHK(q, {ch1, ch0, `LSR_BLK_COUNT})
        $display("word and block done");
        wr(8'hC6, 1, 32'h5A);
        `CHK(ic, 8'h5A)
        `CHK(irqs, 1)
        rd(8'h87, 1, 1);
        `CHK(q[7:0], 8'h00)
        rd(8'h8A, 1, 1);
        `CHK(q[7:0], PID)
        $display("clear and reserved done");
        for (s = 0; s < 3; s = s + 1) begin
            addr_sel <= s[1:0];
            repeat (10) @(posedge clk_sys);
            for (k = 0; k < 3; k = k + 1) begin
                lsr_master_i.st;
                lsr_master_i.xb({(k == 0) ? `LSR_ADDR_GND : (k == 1) ? `LSR_ADDR_FLOAT : `LSR_ADDR_VDD, 2'b01}, r);
                lsr_master_i.sp;
                `CHK(r[0], s != k)
            end
        end
        $display("address select done");
        tally_and_finish;
    end
endmodule
